// ### cpc_pkg.sv
// constants and carrier types for the coherence performance counter block
`default_nettype none
package cpc_pkg;
  // ****************************************************************
  // widths and limits
  // ****************************************************************
  localparam int unsigned CNT_W   = 32;
  localparam int unsigned QUAL_W  = 32;
  localparam int unsigned SEL_W   = 5;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned N_IOP   = 8;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_OVF   = 8'h04;
  localparam logic [7:0] OFF_EVSEL = 8'h08;
  localparam logic [7:0] OFF_QUAL0 = 8'h0C;
  localparam logic [7:0] OFF_QUAL1 = 8'h10;
  localparam logic [7:0] OFF_CNT0  = 8'h14;
  localparam logic [7:0] OFF_CNT1  = 8'h18;
  localparam logic [7:0] OFF_CYC   = 8'h1C;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTL_RUN0 = 0;
  localparam int unsigned CTL_CLR0 = 1;
  localparam int unsigned CTL_RUN1 = 2;
  localparam int unsigned CTL_CLR1 = 3;
  localparam int unsigned CTL_RUNC = 4;
  localparam int unsigned CTL_CLRC = 5;
  localparam int unsigned CTL_STOP = 8;
  localparam int unsigned CTL_IEN  = 9;
  localparam int unsigned EVS_SEL0 = 0;
  localparam int unsigned EVS_SEL1 = 8;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] RST_QUAL = 32'hFFFF_FFFF;
  localparam logic [4:0]  RST_SEL  = 5'h00;
  // ****************************************************************
  // event select codes
  // ****************************************************************
  localparam logic [4:0] EV_NONE   = 5'h00;
  localparam logic [4:0] EV_REQ    = 5'h01;
  localparam logic [4:0] EV_IOP    = 5'h02;
  localparam logic [4:0] EV_MEM    = 5'h03;
  localparam logic [4:0] EV_MEMBUS = 5'h07;
  localparam logic [4:0] EV_IOPB0  = 5'h08;
  localparam logic [4:0] EV_IOPB7  = 5'h0F;
  localparam logic [4:0] EV_TRDROP = 5'h11;
  localparam logic [4:0] EV_TROVF  = 5'h12;
  // ****************************************************************
  // qualifier group starts, one bit marks the first bit of a group
  // ****************************************************************
  localparam logic [31:0] GRP_REQ = 32'h5554_9111;
  localparam logic [31:0] GRP_IOP = 32'h0101_1111;
  localparam logic [31:0] GRP_MEM = 32'h0111_1111;
  localparam logic [31:0] GRP_BUS = 32'h0000_0101;
  localparam logic [31:0] GRP_TRD = 32'h0001_0101;
  // one event source: a pulse plus its attribute bits
  typedef struct packed {
    logic              hit;
    logic [QUAL_W-1:0] attr;
  } cpc_ev_s;
endpackage
`default_nettype wire

// ### cpc_top.sv
// coherence manager performance counters with an AHB-Lite register slave
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module cpc_top (
  input  wire logic                          CLK_I,
  input  wire logic                          RST_I,
  input  wire logic                          CE_I,
  input  wire logic                          HSEL_I,
  input  wire logic [31:0]                   HADDR_I,
  input  wire logic [1:0]                    HTRANS_I,
  input  wire logic                          HWRITE_I,
  input  wire logic [2:0]                    HSIZE_I,
  input  wire logic [31:0]                   HWDATA_I,
  input  wire logic                          HREADY_I,
  output logic                               HREADYOUT_O,
  output logic                               HRESP_O,
  output logic [31:0]                        HRDATA_O,
  input  wire cpc_pkg::cpc_ev_s              REQ_EV_I,
  input  wire cpc_pkg::cpc_ev_s              IOP_EV_I,
  input  wire cpc_pkg::cpc_ev_s              MEM_EV_I,
  input  wire cpc_pkg::cpc_ev_s              MEMBUS_EV_I,
  input  wire cpc_pkg::cpc_ev_s [7:0]        IOPBUS_EV_I,
  input  wire cpc_pkg::cpc_ev_s              TRDROP_EV_I,
  input  wire logic                          TROVF_I,
  output logic                               PERF_OVERFLOW_IRQ_OUT_O
);
  import cpc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [2:0]        run_r;
  logic [2:0]        ovf_r;
  logic [2:0]        ovf_nxt;
  logic              stop_r;
  logic              ien_r;
  logic [SEL_W-1:0]  sel_r [2];
  logic [QUAL_W-1:0] qual_r [2];
  logic [CNT_W-1:0]  cnt_r [3];
  logic              wr_pend_r;
  logic [ADDR_W-1:0] wa_r;
  logic              hready_r;
  logic [31:0]       hrdata_r;
  logic              irq_r;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // and of groups, or of matching bits inside each group
  function automatic logic qual_ok(input logic [QUAL_W-1:0] attr,
                                   input logic [QUAL_W-1:0] q,
                                   input logic [QUAL_W-1:0] grp);
    logic acc;
    logic all;
    acc = 1'b0;
    all = 1'b1;
    for (int i = 0; i < QUAL_W; i++) begin
      if (grp[i] && i != 0) begin
        all = all & acc;
        acc = 1'b0;
      end
      acc = acc | (attr[i] & q[i]);
    end
    return all & acc;
  endfunction

  // qualified event pulse for a select code
  function automatic logic sel_event(input logic [SEL_W-1:0] s,
                                     input logic [QUAL_W-1:0] q);
    logic r;
    logic [2:0] k;
    r = 1'b0;
    k = s[2:0];
    case (s)
      EV_REQ:    r = REQ_EV_I.hit & qual_ok(REQ_EV_I.attr, q, GRP_REQ);
      EV_IOP:    r = IOP_EV_I.hit & qual_ok(IOP_EV_I.attr, q, GRP_IOP);
      EV_MEM:    r = MEM_EV_I.hit & qual_ok(MEM_EV_I.attr, q, GRP_MEM);
      EV_MEMBUS: r = MEMBUS_EV_I.hit & qual_ok(MEMBUS_EV_I.attr, q, GRP_BUS);
      EV_TRDROP: r = TRDROP_EV_I.hit & qual_ok(TRDROP_EV_I.attr, q, GRP_TRD);
      EV_TROVF:  r = TROVF_I;
      EV_NONE:   r = 1'b0;
      default: begin
        if (s >= EV_IOPB0 && s <= EV_IOPB7) begin
          r = IOPBUS_EV_I[k].hit & qual_ok(IOPBUS_EV_I[k].attr, q, GRP_BUS);
        end else begin
          r = 1'b0;
        end
      end
    endcase
    return r;
  endfunction

  // register read multiplexer
  function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      OFF_CTRL: begin
        v[CTL_RUN0] = run_r[0];
        v[CTL_RUN1] = run_r[1];
        v[CTL_RUNC] = run_r[2];
        v[CTL_STOP] = stop_r;
        v[CTL_IEN]  = ien_r;
      end
      OFF_OVF:   v[2:0] = ovf_r;
      OFF_EVSEL: begin
        v[EVS_SEL0 +: SEL_W] = sel_r[0];
        v[EVS_SEL1 +: SEL_W] = sel_r[1];
      end
      OFF_QUAL0: v = qual_r[0];
      OFF_QUAL1: v = qual_r[1];
      OFF_CNT0:  v = cnt_r[0];
      OFF_CNT1:  v = cnt_r[1];
      OFF_CYC:   v = cnt_r[2];
      default:   v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************

  // address phase qualification, only whole-word singles are expected
  wire addr_ph = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire wr_go   = addr_ph & HWRITE_I;
  wire rd_go   = addr_ph & ~HWRITE_I;

  // data phase write strobes per register
  wire wr_ctrl  = wr_pend_r & (wa_r == OFF_CTRL);
  wire wr_ovf   = wr_pend_r & (wa_r == OFF_OVF);
  wire wr_evsel = wr_pend_r & (wa_r == OFF_EVSEL);
  wire wr_qual0 = wr_pend_r & (wa_r == OFF_QUAL0);
  wire wr_qual1 = wr_pend_r & (wa_r == OFF_QUAL1);

  // clear pulses from a control write, read back as zero
  wire [2:0] clr_v = wr_ctrl ? {HWDATA_I[CTL_CLRC], HWDATA_I[CTL_CLR1], HWDATA_I[CTL_CLR0]}
                             : 3'b000;
  // write-one-to-clear of the overflow flags
  wire [2:0] w1c_v = wr_ovf ? HWDATA_I[2:0] : 3'b000;

  // ****************************************************************
  // counting
  // ****************************************************************

  // every counter halts once any flag is up with stop set
  wire frozen = stop_r & (|ovf_r);

  // raw event per counter, the cycle counter's raw event is high every clock
  wire [2:0] ev_v = {1'b1, sel_event(sel_r[1], qual_r[1]), sel_event(sel_r[0], qual_r[0])};

  // increment enables; a counter being cleared does not step
  wire [2:0] inc_v = run_r & ev_v & ~{3{frozen}} & ~clr_v;

  // a step that lands on the all-ones value
  wire [2:0] hit_max;
  assign hit_max[0] = inc_v[0] & (cnt_r[0] == CNT_MAX - 32'h0000_0001);
  assign hit_max[1] = inc_v[1] & (cnt_r[1] == CNT_MAX - 32'h0000_0001);
  assign hit_max[2] = inc_v[2] & (cnt_r[2] == CNT_MAX - 32'h0000_0001);

  // new overflows win over a write-one-to-clear in the same cycle; a control clear blocks the step of its counter
  assign ovf_nxt = hit_max | (ovf_r & ~clr_v & ~w1c_v);

  // counter registers: clear, step or hold
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < 3; i++) begin
        cnt_r[i] <= 32'h0000_0000;
      end
    end else if (CE_I) begin
      for (int i = 0; i < 3; i++) begin
        if (clr_v[i]) begin
          cnt_r[i] <= 32'h0000_0000;
        end else if (inc_v[i]) begin
          cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
        end
      end
    end
  end

  // overflow flags and the interrupt line
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ovf_r <= 3'b000;
      irq_r <= 1'b0;
    end else if (CE_I) begin
      ovf_r <= ovf_nxt;
      irq_r <= ien_r & (|ovf_nxt);
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************

  // control register
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      run_r  <= 3'b000;
      stop_r <= 1'b0;
      ien_r  <= 1'b0;
    end else if (CE_I && wr_ctrl) begin
      run_r  <= {HWDATA_I[CTL_RUNC], HWDATA_I[CTL_RUN1], HWDATA_I[CTL_RUN0]};
      stop_r <= HWDATA_I[CTL_STOP];
      ien_r  <= HWDATA_I[CTL_IEN];
    end
  end

  // event select and qualifier registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sel_r[0]  <= RST_SEL;
      sel_r[1]  <= RST_SEL;
      qual_r[0] <= RST_QUAL;
      qual_r[1] <= RST_QUAL;
    end else if (CE_I) begin
      if (wr_evsel) begin
        sel_r[0] <= HWDATA_I[EVS_SEL0 +: SEL_W];
        sel_r[1] <= HWDATA_I[EVS_SEL1 +: SEL_W];
      end
      if (wr_qual0) begin
        qual_r[0] <= HWDATA_I;
      end
      if (wr_qual1) begin
        qual_r[1] <= HWDATA_I;
      end
    end
  end

  // ****************************************************************
  // bus slave timing
  // ****************************************************************

  // writes take one wait state so a following read sees the new value
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 8'h00;
      hready_r  <= 1'b1;
    end else if (CE_I) begin
      wr_pend_r <= wr_go;
      hready_r  <= ~wr_go;
      if (wr_go) begin
        wa_r <= HADDR_I[ADDR_W-1:0];
      end
    end
  end

  // read data is fetched in the address phase, unmapped reads give zero
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      hrdata_r <= 32'h0000_0000;
    end else if (CE_I && rd_go) begin
      hrdata_r <= rd_mux(HADDR_I[ADDR_W-1:0]);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign HREADYOUT_O             = hready_r;
  assign HRESP_O                 = 1'b0;
  assign HRDATA_O                = hrdata_r;
  assign PERF_OVERFLOW_IRQ_OUT_O = irq_r;

endmodule
`default_nettype wire

// ### cpc_top_chk.sv
// assertion checker for the performance counter register slave
`timescale 1ns/100ps
`default_nettype none
module cpc_top_chk (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  input  wire logic        HREADYOUT_O,
  input  wire logic        HRESP_O,
  input  wire logic [31:0] HRDATA_O,
  input  wire logic        PERF_OVERFLOW_IRQ_OUT_O
);
  import cpc_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ****************************************************************
  // bus tracking
  // ****************************************************************
  logic       take;
  logic       wdat;
  logic       wp_r;
  logic       ien_r;
  logic [7:0] wa_r;
  assign take = HSEL_I & HTRANS_I[1] & HREADY_I & CE_I;
  assign wdat = wp_r & CE_I;
  // write address phase and shadow of the interrupt enable
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wp_r  <= 1'h0;
      wa_r  <= 8'h00;
      ien_r <= 1'h0;
    end else if (CE_I) begin
      wp_r <= take & HWRITE_I;
      wa_r <= HADDR_I[7:0];
      if (wp_r && wa_r == OFF_CTRL) ien_r <= HWDATA_I[CTL_IEN];
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  resp_okay_a: assert property (!HRESP_O) else $error("response not okay");
  rd_nowait_a: assert property (take && !HWRITE_I |=> HREADYOUT_O) else $error("read stalled");
  wr_wait_a: assert property (take && HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O) else $error("write wait wrong");
  one_wait_a: assert property (!HREADYOUT_O |=> HREADYOUT_O) else $error("wait too long");
  rdata_hold_a: assert property (!$past(take && !HWRITE_I) |-> $stable(HRDATA_O)) else $error("read data moved");
  rst_vals_a: assert property ($fell(RST_I) |-> HREADYOUT_O && !PERF_OVERFLOW_IRQ_OUT_O && HRDATA_O == 32'h0000_0000)
    else $error("bad reset outputs");
  clr_irq_a: assert property (wdat && wa_r == OFF_CTRL && HWDATA_I[CTL_CLR0] && HWDATA_I[CTL_CLR1]
    && HWDATA_I[CTL_CLRC] |=> !PERF_OVERFLOW_IRQ_OUT_O) else $error("irq kept after clear");
  w1c_irq_a: assert property (wdat && wa_r == OFF_OVF && HWDATA_I[2:0] == 3'h7
    |=> !PERF_OVERFLOW_IRQ_OUT_O) else $error("irq kept after flag clear");
  irq_en_a: assert property (!ien_r && !$past(ien_r) |-> !PERF_OVERFLOW_IRQ_OUT_O) else $error("irq not enabled");
endmodule
`default_nettype wire

// ### cpc_top_bench.sv
// self-checking bench for the coherence performance counters
`timescale 1ns/100ps
`default_nettype none
module cpc_top_bench;
  import cpc_pkg::*;
  logic             CLK_I = 1'h0;
  logic             RST_I = 1'h1;
  logic             CE_I = 1'h1;
  logic             HSEL_I = 1'h0;
  logic             HWRITE_I = 1'h0;
  logic             TROVF_I = 1'h0;
  logic [31:0]      HADDR_I = 32'h0000_0000;
  logic [31:0]      HWDATA_I = 32'h0000_0000;
  logic [1:0]       HTRANS_I = 2'h0;
  logic [2:0]       HSIZE_I = 3'h2;
  logic             HREADYOUT_O;
  logic             HRESP_O;
  logic             IRQ;
  logic [31:0]      HRDATA_O;
  cpc_ev_s          ev_v [5] = '{default: '0};
  cpc_ev_s [7:0]    iob = '0;
  logic [31:0]      r, r2, e0, e1;
  integer           seed = 32'h1a44;
  int               n_errors = 0;
  int               checks_done = 0;
  cpc_top dut_u (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
    .HREADY_I(HREADYOUT_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O),
    .REQ_EV_I(ev_v[0]), .IOP_EV_I(ev_v[1]), .MEM_EV_I(ev_v[2]), .MEMBUS_EV_I(ev_v[3]),
    .IOPBUS_EV_I(iob), .TRDROP_EV_I(ev_v[4]), .TROVF_I(TROVF_I), .PERF_OVERFLOW_IRQ_OUT_O(IRQ));
  // ****************************************************************
  // clock, checks and bus tasks
  // ****************************************************************
  always #5 CLK_I = ~CLK_I;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // wait for hready sampled high, bounded
  task automatic wt;
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge CLK_I);
      if (HREADYOUT_O === 1'h1) break;
    end
    if (i == 16) begin
      chk(0, 1, "bus hang");
      summarize();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL_I <= 1'h1;
    HTRANS_I <= 2'h2;
    HADDR_I <= {24'h00_0000, a};
    HWRITE_I <= w;
    wt();
    HSEL_I <= 1'h0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    wt();
    r = HRDATA_O;
  endtask
  // ****************************************************************
  // event model
  // ****************************************************************
  // every group needs one bit set in both attribute and qualifier
  function automatic bit qm(input logic [31:0] a, input logic [31:0] q, input logic [31:0] g);
    bit ok = 1;
    bit any = 0;
    for (int i = 0; i < 32; i++) begin
      if (g[i] && i > 0) begin
        ok &= any;
        any = 0;
      end
      any |= a[i] & q[i];
    end
    return ok & any;
  endfunction
  function automatic bit hit(input logic [4:0] s, input logic [31:0] q);
    case (s)
      EV_REQ: return ev_v[0].hit && qm(ev_v[0].attr, q, GRP_REQ);
      EV_IOP: return ev_v[1].hit && qm(ev_v[1].attr, q, GRP_IOP);
      EV_MEM: return ev_v[2].hit && qm(ev_v[2].attr, q, GRP_MEM);
      EV_MEMBUS: return ev_v[3].hit && qm(ev_v[3].attr, q, GRP_BUS);
      EV_TRDROP: return ev_v[4].hit && qm(ev_v[4].attr, q, GRP_TRD);
      EV_TROVF: return TROVF_I;
      default: return s >= EV_IOPB0 && s <= EV_IOPB7 && iob[s[2:0]].hit && qm(iob[s[2:0]].attr, q, GRP_BUS);
    endcase
  endfunction
  function automatic cpc_ev_s rv(input bit on);
    return on ? {1'($random(seed)), 32'($random(seed))} : '0;
  endfunction
  // random events on every source; tally what the counters should see
  task automatic burst(input bit c, input int n, input logic [4:0] s, input logic [31:0] q);
    for (int i = 0; i <= n; i++) begin
      @(posedge CLK_I);
      e0 += 32'(c & hit(s, q));
      e1 += 32'(c & hit(s, 32'hFFFF_FFFF));
      for (int k = 0; k < 5; k++) ev_v[k] <= rv(i < n);
      for (int k = 0; k < 8; k++) iob[k] <= rv(i < n);
      TROVF_I <= (i < n) ? 1'($random(seed)) : 1'h0;
    end
  endtask
  task automatic run(input logic [4:0] s);
    logic [31:0] q;
    q = $random(seed) | $random(seed);
    e0 = 0;
    e1 = 0;
    bus(1, OFF_QUAL0, q);
    bus(1, OFF_QUAL1, 32'hFFFF_FFFF);
    bus(1, OFF_EVSEL, {19'h0_0000, s, 3'h0, s});
    bus(1, OFF_CTRL, 32'h0000_003F);
    burst(1, 24, s, q);
    bus(1, OFF_CTRL, 32'h0000_0000);
    burst(0, 8, s, q);
    bus(0, OFF_CNT0, 0);
    chk(r, e0, "count0");
    bus(0, OFF_CNT1, 0);
    chk(r, e1, "count1");
    $display("code %0d done", s);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'h0;
    bus(0, OFF_QUAL0, 0);
    chk(r, RST_QUAL, "qual reset");
    bus(1, 8'h40, 32'h1234_5678);
    bus(0, 8'h40, 0);
    chk(r, 0, "unmapped");
    for (int c = 0; c < 20; c++) run(5'(c));
    bus(0, OFF_CYC, 0);
    r2 = r;
    bus(0, OFF_CYC, 0);
    chk(r, r2, "cycle hold");
    bus(0, OFF_OVF, 0);
    chk(r, 0, "flags");
    bus(1, OFF_OVF, 32'h0000_0007);
    chk(32'(IRQ), 0, "irq");
    bus(1, OFF_CTRL, 32'h0000_002A);
    bus(0, OFF_CYC, 0);
    chk(r, 0, "cycle clear");
    bus(0, OFF_CNT0, 0);
    chk(r, 0, "count clear");
    $display("clear test done");
    // clock enable low freezes the cycle counter; back to back reads are two cycles apart
    bus(1, OFF_CTRL, 32'h0000_0030);
    bus(0, OFF_CYC, 0);
    r2 = r;
    CE_I <= 1'h0;
    repeat (5) @(posedge CLK_I);
    CE_I <= 1'h1;
    bus(0, OFF_CYC, 0);
    chk(r, r2 + 32'h0000_0002, "cycle freeze");
    $display("enable test done");
    // second reset in mid run brings control, cycle counter and overflow flags back
    RST_I <= 1'h1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'h0;
    bus(0, OFF_CTRL, 0);
    chk(r, 0, "ctrl after reset");
    bus(0, OFF_CYC, 0);
    chk(r, 0, "cycle after reset");
    bus(0, OFF_OVF, 0);
    chk(r, 0, "flags after reset");
    $display("reset test done");
    summarize();
  end
endmodule
bind cpc_top cpc_top_chk chk_u (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O), .PERF_OVERFLOW_IRQ_OUT_O(PERF_OVERFLOW_IRQ_OUT_O));
`default_nettype wire
